//--- timer_cc_cfg.svh
// Constants of the timer capture/compare unit: register byte offsets,
// reset values, clock-select codes and pin timing figures.
// Assumes it is included by its bare name from the package and the design.
`ifndef TIMER_CC_CFG_SVH
`define TIMER_CC_CFG_SVH

// Register byte offsets on the Avalon-MM slave (one aligned word each)
`define TCC_ADDR_W        6
`define TCC_OFS_CTRL_TWO  6'h00
`define TCC_OFS_CTRL_ONE  6'h04
`define TCC_OFS_FLAGS     6'h08
`define TCC_OFS_CAP1_HIGH 6'h0c
`define TCC_OFS_CAP1_LOW  6'h10
`define TCC_OFS_CAP2_HIGH 6'h14
`define TCC_OFS_CAP2_LOW  6'h18
`define TCC_OFS_CMP1_HIGH 6'h1c
`define TCC_OFS_CMP1_LOW  6'h20
`define TCC_OFS_CMP2_HIGH 6'h24
`define TCC_OFS_CMP2_LOW  6'h28
`define TCC_OFS_CNT_HIGH  6'h2c
`define TCC_OFS_CNT_LOW   6'h30

// Reset values and the counter top value
`define TCC_CNT_RESET     16'hfffc
`define TCC_CNT_MAX       16'hffff
`define TCC_CMP_RESET     16'h8000
`define TCC_CTRL_RESET    8'h00

// Clock-select codes {clock_select_high, clock_select_low}
`define TCC_CLK_DIV4      2'b00
`define TCC_CLK_DIV2      2'b01
`define TCC_CLK_DIV8      2'b10
`define TCC_CLK_EXT       2'b11

// Least CPU clocks between two active external edges
`define TCC_EXT_MIN_GAP   4

`endif

//--- timer_cc_pkg.sv
// Types of the timer capture/compare unit: control and flag layouts.
// Assumes timer_cc_cfg.svh sits in the same folder.
`include "timer_cc_cfg.svh"

package timer_cc_pkg;

  // timer_control_one, bit 7 down to bit 0
  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_level_two;
    logic force_level_one;
    logic compare_level_two;
    logic compare_level_one;
    logic capture_edge_one;
  } ctrl_one_t;

  // timer_control_two, bit 7 down to bit 0
  typedef struct packed {
    logic pwm_select;
    logic single_pulse_select;
    logic compare_pin_enable_two;
    logic compare_pin_enable_one;
    logic capture_edge_two;
    logic ext_edge_select;
    logic clock_select_high;
    logic clock_select_low;
  } ctrl_two_t;

  // timer_flags_reg, bit 7 down to bit 0
  typedef struct packed {
    logic [2:0] spare;
    logic       overflow_flag;
    logic [1:0] compare_flag;
    logic [1:0] capture_flag;
  } flags_t;

endpackage

//--- timer_capture_compare_unit.sv
// Capture, compare and external-clock logic around a 16-bit free-running timer.
// Assumes a host on Avalon-MM with waitrequest and asynchronous timer pins.
`include "timer_cc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_capture_compare_unit #(
  parameter int BUS_DATA_W = 32               // Avalon data width
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // Avalon-MM slave
  input  wire logic [`TCC_ADDR_W-1:0]  address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [BUS_DATA_W-1:0]   writedata,
  input  wire logic [BUS_DATA_W/8-1:0] byteenable,
  output logic      [BUS_DATA_W-1:0]   readdata,
  output logic                         waitrequest,
  // Timer pins and CPU mask
  input  wire logic                    ext_count_pin,
  input  wire logic                    capture_pin_one,
  input  wire logic                    capture_pin_two,
  input  wire logic                    irq_mask,
  output logic      [1:0]              compare_out_pin,
  output logic      [1:0]              compare_pin_drive,
  output logic                         timer_irq
);

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (BUS_DATA_W < 8 || BUS_DATA_W % 8 != 0) begin : g_width_check
    $error("BUS_DATA_W must be a multiple of 8");
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  timer_cc_pkg::ctrl_one_t ctrl_one;          // timer_control_one
  timer_cc_pkg::ctrl_two_t ctrl_two;          // timer_control_two
  timer_cc_pkg::flags_t    flags;             // timer_flags_reg view
  logic [15:0]             counter;           // Free-running counter
  logic [2:0]              presc;             // Internal prescaler
  logic [15:0]             capture_value [2]; // capture_value_one/two
  logic [15:0]             compare_value [2]; // compare_value_one/two
  logic [1:0]              capture_flag;      // Sticky capture flags
  logic [1:0]              compare_flag;      // Sticky compare flags
  logic                    overflow_flag;     // Sticky wrap flag
  logic [1:0]              cap_armed;         // Status read saw flag set
  logic [1:0]              cmp_armed;
  logic                    ovf_armed;
  logic [1:0]              cap_lock;          // High byte read, waiting low
  logic [1:0]              cmp_hold;          // High byte written, waiting low
  logic [1:0]              cmp_eq_d;          // Last cycle equality
  logic [2:0]              ext_sync;          // Two sync stages plus history
  logic [2:0]              cap_sync [2];      // Same for capture pins

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // The request is taken at the edge where waitrequest is low
  wire       accept   = (read | write) & ~waitrequest;
  wire       wr_acc   = accept & write & byteenable[0];
  wire       rd_acc   = accept & read;
  wire       any_acc  = accept & (read | (write & byteenable[0]));
  wire [7:0] wbyte    = writedata[7:0];
  wire       hit_c2   = address == `TCC_OFS_CTRL_TWO;
  wire       hit_c1   = address == `TCC_OFS_CTRL_ONE;
  wire       hit_fl   = address == `TCC_OFS_FLAGS;
  wire       hit_ch1  = address == `TCC_OFS_CAP1_HIGH;
  wire       hit_cl1  = address == `TCC_OFS_CAP1_LOW;
  wire       hit_ch2  = address == `TCC_OFS_CAP2_HIGH;
  wire       hit_cl2  = address == `TCC_OFS_CAP2_LOW;
  wire       hit_mh1  = address == `TCC_OFS_CMP1_HIGH;
  wire       hit_ml1  = address == `TCC_OFS_CMP1_LOW;
  wire       hit_mh2  = address == `TCC_OFS_CMP2_HIGH;
  wire       hit_ml2  = address == `TCC_OFS_CMP2_LOW;
  wire       hit_nh   = address == `TCC_OFS_CNT_HIGH;
  wire       hit_nl   = address == `TCC_OFS_CNT_LOW;
  wire [1:0] cap_hi_rd = {rd_acc & hit_ch2, rd_acc & hit_ch1};
  wire [1:0] cap_lo_rd = {rd_acc & hit_cl2, rd_acc & hit_cl1};
  wire [1:0] cap_lo_ac = {any_acc & hit_cl2, any_acc & hit_cl1};
  wire [1:0] cmp_hi_wr = {wr_acc & hit_mh2, wr_acc & hit_mh1};
  wire [1:0] cmp_lo_wr = {wr_acc & hit_ml2, wr_acc & hit_ml1};
  wire [1:0] cmp_lo_ac = {any_acc & hit_ml2, any_acc & hit_ml1};
  wire       cnt_lo_ac = any_acc & hit_nl;
  wire       cnt_lo_wr = wr_acc & hit_nl;
  wire       flags_rd  = rd_acc & hit_fl;

  // Force bits act on the write itself and are never stored
  wire       force_wr  = wr_acc & hit_c1;
  wire       mode_on   = ctrl_two.pwm_select | ctrl_two.single_pulse_select;
  wire [1:0] force_evt = {2{force_wr & ~mode_on}} & {wbyte[4], wbyte[3]};

  assign flags = '{spare: 3'b000, overflow_flag: overflow_flag,
                   compare_flag: compare_flag, capture_flag: capture_flag};

  // Read mux; unmapped offsets read as zero
  wire [7:0] rbyte =
      hit_c2  ? ctrl_two :
      hit_c1  ? ctrl_one :
      hit_fl  ? flags :
      hit_ch1 ? capture_value[0][15:8] : hit_cl1 ? capture_value[0][7:0] :
      hit_ch2 ? capture_value[1][15:8] : hit_cl2 ? capture_value[1][7:0] :
      hit_mh1 ? compare_value[0][15:8] : hit_ml1 ? compare_value[0][7:0] :
      hit_mh2 ? compare_value[1][15:8] : hit_ml2 ? compare_value[1][7:0] :
      hit_nh  ? counter[15:8] : hit_nl ? counter[7:0] : 8'h00;

  // ==========================================================================
  // Bus handshake: one wait cycle, readdata captured with the answer
  // ==========================================================================
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= '0;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if ((read | write) & waitrequest) begin
        readdata <= {{(BUS_DATA_W-8){1'b0}}, rbyte};
      end
    end
  end

  // Control registers; byte lane 0 carries the data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_one <= `TCC_CTRL_RESET;
      ctrl_two <= `TCC_CTRL_RESET;
    end else begin
      if (force_wr) begin
        ctrl_one <= wbyte & 8'he7;
      end
      if (wr_acc & hit_c2) begin
        ctrl_two <= wbyte;
      end
    end
  end

  // ==========================================================================
  // Time base: prescaler, external clock, counter
  // ==========================================================================
  wire [1:0] clk_sel  = {ctrl_two.clock_select_high, ctrl_two.clock_select_low};
  wire       ext_mode = clk_sel == `TCC_CLK_EXT;
  wire       div2     = clk_sel == `TCC_CLK_DIV2;
  // Edge detect reads only the second stage and its history
  wire       ext_rise = ext_sync[1] & ~ext_sync[2];
  wire       ext_fall = ~ext_sync[1] & ext_sync[2];
  wire       ext_edge = ctrl_two.ext_edge_select ? ext_rise : ext_fall;
  wire       int_tick = div2 ? presc[0] :
                        (clk_sel == `TCC_CLK_DIV4) ? (&presc[1:0]) : (&presc);
  // External edges are taken one per CPU clock, so they must be spaced
  wire       tick     = ext_mode ? ext_edge : int_tick;
  wire       wrap     = tick & ~cnt_lo_wr & (counter == `TCC_CNT_MAX);

  // External-pin synchroniser and prescaler; the timer steps on the CPU clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_sync <= 3'b000;
      presc    <= 3'b000;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_count_pin};
      presc    <= presc + 3'd1;
    end
  end

  // Counter: only FFFC is ever loaded
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      counter <= `TCC_CNT_RESET;
    end else if (cnt_lo_wr) begin
      counter <= `TCC_CNT_RESET;
    end else if (tick) begin
      counter <= counter + 16'd1;
    end
  end

  // Overflow flag; a wrap in the clearing cycle wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      ovf_armed     <= 1'b0;
    end else begin
      overflow_flag <= wrap | (overflow_flag & ~(ovf_armed & cnt_lo_ac));
      if (ovf_armed & cnt_lo_ac) begin
        ovf_armed <= 1'b0;
      end else if (flags_rd & readdata[4]) begin
        ovf_armed <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Capture and compare channels
  // ==========================================================================
  wire [1:0] cap_pin  = {capture_pin_two, capture_pin_one};
  wire [1:0] cap_edge = {ctrl_two.capture_edge_two, ctrl_one.capture_edge_one};
  wire [1:0] cmp_lvl  = {ctrl_one.compare_level_two, ctrl_one.compare_level_one};
  wire [1:0] cmp_en   = {ctrl_two.compare_pin_enable_two, ctrl_two.compare_pin_enable_one};
  wire [1:0] cap_evt;
  wire [1:0] cmp_evt;

  for (genvar i = 0; i < 2; i++) begin : g_chan
    // Capture: pin two is watched in every mode, pin one only while no pulse mode is on
    wire rise     = cap_sync[i][1] & ~cap_sync[i][2];
    wire fall     = ~cap_sync[i][1] & cap_sync[i][2];
    wire pin_edge = cap_edge[i] ? rise : fall;
    wire allowed  = (i == 1) | ~mode_on;
    assign cap_evt[i] = pin_edge & allowed & ~cap_lock[i];
    wire cap_clr  = cap_armed[i] & cap_lo_ac[i];

    // Compare target: plus one unless the timer runs at half CPU rate
    wire [15:0] target = div2 ? compare_value[i] : compare_value[i] + 16'd1;
    wire        eq     = (counter == target) & ~cmp_hold[i];
    assign cmp_evt[i]  = eq & ~cmp_eq_d[i];
    wire cmp_clr  = cmp_armed[i] & cmp_lo_ac[i];

    // Capture synchroniser, value, flag and lock
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        cap_sync[i]      <= 3'b000;
        capture_value[i] <= 16'h0000;
        capture_flag[i]  <= 1'b0;
        cap_armed[i]     <= 1'b0;
        cap_lock[i]      <= 1'b0;
      end else begin
        cap_sync[i] <= {cap_sync[i][1:0], cap_pin[i]};
        if (cap_evt[i]) begin
          capture_value[i] <= counter;
        end
        // A capture in the clearing cycle keeps the flag set
        capture_flag[i] <= cap_evt[i] | (capture_flag[i] & ~cap_clr);
        if (cap_clr) begin
          cap_armed[i] <= 1'b0;
        end else if (flags_rd & readdata[i]) begin
          cap_armed[i] <= 1'b1;
        end
        if (cap_lo_rd[i]) begin
          cap_lock[i] <= 1'b0;
        end else if (cap_hi_rd[i]) begin
          cap_lock[i] <= 1'b1;
        end
      end
    end

    // Compare value, hold, flag and pin latch
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        compare_value[i]   <= `TCC_CMP_RESET;
        cmp_hold[i]        <= 1'b0;
        cmp_eq_d[i]        <= 1'b0;
        compare_flag[i]    <= 1'b0;
        cmp_armed[i]       <= 1'b0;
        compare_out_pin[i] <= 1'b0;
      end else begin
        cmp_eq_d[i] <= eq;
        if (cmp_hi_wr[i]) begin
          compare_value[i][15:8] <= wbyte;
          cmp_hold[i]            <= 1'b1;
        end else if (cmp_lo_wr[i]) begin
          compare_value[i][7:0]  <= wbyte;
          cmp_hold[i]            <= 1'b0;
        end
        compare_flag[i] <= cmp_evt[i] | (compare_flag[i] & ~cmp_clr);
        if (cmp_clr) begin
          cmp_armed[i] <= 1'b0;
        end else if (flags_rd & readdata[2+i]) begin
          cmp_armed[i] <= 1'b1;
        end
        // Force wins over a match in the same cycle; both drive the level
        if (force_evt[i]) begin
          compare_out_pin[i] <= wbyte[1+i];
        end else if (cmp_evt[i] & cmp_en[i]) begin
          compare_out_pin[i] <= cmp_lvl[i];
        end
      end
    end
  end

  // Pin drive mirrors the enable bits; when clear the pin is general I/O
  assign compare_pin_drive = {ctrl_two.compare_pin_enable_two, ctrl_two.compare_pin_enable_one};

  // ==========================================================================
  // Interrupt request: pending flags stay until the mask opens
  // ==========================================================================
  wire irq_any = (|capture_flag & ctrl_one.capture_irq_enable) |
                 (|compare_flag & ctrl_one.compare_irq_enable) |
                 (overflow_flag & ctrl_one.overflow_irq_enable);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_any & ~irq_mask;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Status read that returned the first capture flag set
  sequence status_saw_cap0;
    flags_rd & readdata[0];
  endsequence
  // Low capture byte access with no fresh capture in that cycle
  sequence low_cap0_access;
    cap_lo_ac[0] & ~cap_evt[0];
  endsequence

  // Counter reload and wrap

  cnt_reload_a: assert property (cnt_lo_wr |=> counter == 16'hfffc)
    else $error("counter not reloaded to fffc");
  ovf_set_a: assert property (wrap |=> overflow_flag)
    else $error("wrap did not set overflow");
  // External edges step the counter by one
  ext_tick_a: assert property (ext_mode & ext_edge & ~cnt_lo_wr |=> counter == $past(counter) + 16'd1)
    else $error("external edge did not step counter");
  // Capture channels: latch, lock, pulse modes and clearing
  cap_latch_a: assert property (cap_evt[1] |=> capture_value[1] == $past(counter) && capture_flag[1])
    else $error("capture two did not latch counter");
  cap_lock_a: assert property (cap_lock[1] |=> capture_value[1] == $past(capture_value[1]))
    else $error("capture while locked");
  mode_cap_a: assert property (mode_on |-> ~cap_evt[0])
    else $error("capture one active in pulse mode");
  // Clearing needs the armed status read first, then the low byte access
  cap_clear_a: assert property (status_saw_cap0 ##1 (~cap_lo_ac[0] [*2]) ##1 low_cap0_access
                                |=> ~capture_flag[0])
    else $error("capture flag not cleared");
  // Compare channels: hold, pin level and force
  cmp_hold_a: assert property (cmp_hold[0] & ~compare_flag[0] |=> ~compare_flag[0])
    else $error("compare during hold");
  cmp_pin_a: assert property (cmp_evt[0] & cmp_en[0] & ~force_evt[0]
                              |=> compare_out_pin[0] == $past(cmp_lvl[0]))
    else $error("match did not drive level");
  force_pin_a: assert property (force_evt[1] & ~cmp_evt[1] & ~compare_flag[1]
                                |=> compare_out_pin[1] == $past(wbyte[2]) && ~compare_flag[1])
    else $error("force misbehaved");
  // Interrupt follows the enabled flags, and the mask holds it back
  irq_a: assert property (irq_any & ~irq_mask ##1 irq_any & ~irq_mask |-> timer_irq)
    else $error("interrupt not raised");
  irq_masked_a: assert property (irq_mask |=> ~timer_irq)
    else $error("interrupt raised while masked");

endmodule

`default_nettype wire

//--- pin_partner_model.sv
// Partner model: pulse sources on the capture pins and the external count pin.
// Assumes the bench calls its tasks hierarchically and it shares core_clk.
`timescale 1ns/1ps
`default_nettype none

module pin_partner_model (
  input  wire logic core_clk,
  output logic      ext_count_pin,
  output logic      capture_pin_one,
  output logic      capture_pin_two
);
  // ==========================================================
  // Idle levels: pins rest low between events
  initial begin
    ext_count_pin   = 1'b0;
    capture_pin_one = 1'b0;
    capture_pin_two = 1'b0;
  end

  // ==========================================================
  // External edges nine CPU clocks apart, above the least gap
  task automatic ext(input int n);
    repeat (n) begin
      @(posedge core_clk) ext_count_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
  endtask

  // One rise and one fall on a capture pin, long enough for the sync flops
  task automatic cap(input int ch);
    @(posedge core_clk);
    if (ch == 0) capture_pin_one <= 1'b1;
    else capture_pin_two <= 1'b1;
    repeat (6) @(posedge core_clk);
    if (ch == 0) capture_pin_one <= 1'b0;
    else capture_pin_two <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

`default_nettype wire

//--- test_timer_capture_compare_unit.sv
// Self-checking bench for the timer capture/compare unit over Avalon-MM.
// Assumes the partner model drives the timer pins and one 250 MHz clock.
`include "timer_cc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module test_timer_capture_compare_unit;
  logic        core_clk = 1'b0;   // CPU clock
  logic        rst;               // Async reset
  logic [5:0]  address;           // Byte address
  logic        read;              // Read strobe
  logic        write;             // Write strobe
  logic [31:0] writedata;         // Write data
  logic [3:0]  byteenable;        // Byte lanes
  logic [31:0] readdata;          // Read data
  logic        waitrequest;       // Slave stall
  logic        irq_mask;          // CPU global mask
  logic        ext_count_pin, capture_pin_one, capture_pin_two;
  logic [1:0]  compare_out_pin, compare_pin_drive;
  logic        timer_irq;
  int          n_mismatch = 0, compares = 0, cyc = 0;

  always #2 core_clk = ~core_clk;

  timer_capture_compare_unit DUT (.core_clk(core_clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .ext_count_pin(ext_count_pin),
    .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
    .irq_mask(irq_mask), .compare_out_pin(compare_out_pin),
    .compare_pin_drive(compare_pin_drive), .timer_irq(timer_irq));

  pin_partner_model P (.core_clk(core_clk), .ext_count_pin(ext_count_pin),
    .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two));

  // ==========================================================
  // Verdict and compare helpers
  task automatic results;
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results;
    end
  end

  // ==========================================================
  // Avalon-MM master: hold the request until waitrequest is seen low
  task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge core_clk);
    address   <= a;
    writedata <= {24'h0, d};
    read      <= ~w;
    write     <= w;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(a, 1'b1, d, q);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(a, 1'b0, 8'h00, q);
    chk({24'h0, q}, {24'h0, e});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst        <= 1'b1;
    address    <= 6'h00;
    read       <= 1'b0;
    write      <= 1'b0;
    writedata  <= 32'h0;
    byteenable <= 4'h1;
    irq_mask   <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdc(`TCC_OFS_CMP1_HIGH, 8'h80);
    rdc(`TCC_OFS_CMP2_LOW, 8'h00);
    rdc(6'h3c, 8'h00);
    chk(compare_out_pin, 2'b00);
    // A write with lane 0 off is answered but ignored
    byteenable <= 4'h0;
    wr(`TCC_OFS_CMP2_HIGH, 8'h12);
    byteenable <= 4'h1;
    rdc(`TCC_OFS_CMP2_HIGH, 8'h80);
    repeat (30) @(posedge core_clk);
    rdc(`TCC_OFS_FLAGS, 8'h10);
    // External rising-edge count, pin one owned; counter low write reloads
    wr(`TCC_OFS_CTRL_TWO, 8'h17);
    wr(`TCC_OFS_CNT_LOW, 8'h00);
    rdc(`TCC_OFS_CNT_LOW, 8'hfc);
    rdc(`TCC_OFS_FLAGS, 8'h00);
    chk(compare_pin_drive, 2'b01);
    wr(`TCC_OFS_CTRL_ONE, 8'h83);
    wr(`TCC_OFS_CMP1_HIGH, 8'hff);
    rdc(`TCC_OFS_FLAGS, 8'h00);
    wr(`TCC_OFS_CMP1_LOW, 8'hfe);
    irq_mask <= 1'b1;
    P.cap(0);
    chk(timer_irq, 1'b0);
    irq_mask <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(timer_irq, 1'b1);
    rdc(`TCC_OFS_FLAGS, 8'h01);
    rdc(`TCC_OFS_CAP1_LOW, 8'hfc);
    rdc(`TCC_OFS_FLAGS, 8'h00);
    // Reading the high byte locks channel two
    rdc(`TCC_OFS_CAP2_HIGH, 8'h00);
    P.cap(1);
    rdc(`TCC_OFS_FLAGS, 8'h00);
    rdc(`TCC_OFS_CAP2_LOW, 8'h00);
    // Off the divide-by-two clock the match lands at value plus one
    P.ext(2);
    chk(compare_out_pin, 2'b00);
    rdc(`TCC_OFS_CNT_LOW, 8'hfe);
    P.ext(1);
    chk(compare_out_pin, 2'b01);
    P.cap(1);
    rdc(`TCC_OFS_FLAGS, 8'h06);
    rdc(`TCC_OFS_CAP2_LOW, 8'hff);
    // Force copies the level without a flag, but not in pulse modes
    wr(`TCC_OFS_CTRL_ONE, 8'h94);
    @(posedge core_clk);
    chk(compare_out_pin, 2'b11);
    rdc(`TCC_OFS_FLAGS, 8'h04);
    wr(`TCC_OFS_CTRL_TWO, 8'h57);
    wr(`TCC_OFS_CTRL_ONE, 8'h91);
    @(posedge core_clk);
    chk(compare_out_pin, 2'b11);
    P.cap(0);
    rdc(`TCC_OFS_FLAGS, 8'h04);
    results;
  end
endmodule

`default_nettype wire
